// file: tb/testbench.sv
// Testbench joining master and slave ends across one link, driving the master's request side.
// Assumes the design files and tw_link_asserts are compiled first.
`timescale 1ns/100ps
module testbench
	import tw_pkg::*;
;
	logic		ref_clk;
	logic		reset_n;
	logic		pin_sel;
	logic		ovr_en;
	logic [6:0]	ovr_addr;
	logic		req;
	tw_cmd_e	cmd;
	logic [6:0]	dev;
	logic [15:0]	reg_a;
	logic [15:0]	wdat;
	logic [3:0]	nb;
	logic		busy;
	logic		rvalid;
	logic [7:0]	rbyte;
	logic		nack_err;
	logic		wr_strobe;
	logic [15:0]	wr_addr;
	logic [15:0]	wr_data;
	int		failures;
	int		n_checks;
	int		n_wr;
	logic [7:0]	got[$];
	tw_bus_if u_tw_bus_if();
	tw_slave u_tw_slave (.ref_clk(ref_clk), .reset_n(reset_n), .bus(u_tw_bus_if), .slave_address_select_pin(pin_sel),
		.addr_override_en(ovr_en), .addr_override(ovr_addr), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
		.wr_data(wr_data));
	tw_master u_tw_master (.ref_clk(ref_clk), .reset_n(reset_n), .bus(u_tw_bus_if), .req(req), .cmd(cmd), .dev_addr(dev),
		.reg_addr(reg_a), .wdata(wdat), .nbytes(nb), .busy(busy), .rvalid(rvalid), .rbyte(rbyte), .nack_err(nack_err));
	tw_link_asserts u_tw_link_asserts (.ref_clk(ref_clk), .reset_n(reset_n), .scl_oe(u_tw_bus_if.scl_oe),
		.sda_m_oe(u_tw_bus_if.sda_m_oe), .sda_s_oe(u_tw_bus_if.sda_s_oe), .scl(u_tw_bus_if.scl), .sda(u_tw_bus_if.sda));
	task stop_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task check(input logic [15:0] g, input logic [15:0] e, input string m);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask
	// One transfer; collects read bytes and counts written words until busy drops
	task xfer(input tw_cmd_e c, input logic [6:0] d, input logic [15:0] a, input logic [15:0] w, input logic [3:0] n);
		int k;
		got.delete();
		n_wr = 0;
		cmd = c;
		dev = d;
		reg_a = a;
		wdat = w;
		nb = n;
		req = 1'b1;
		@(posedge ref_clk);
		#10 req = 1'b0;
		for (k = 0; k < 4000; k++)
		begin
			@(posedge ref_clk);
			#10;
			if (rvalid === 1'b1)
				got.push_back(rbyte);
			if (wr_strobe === 1'b1)
				n_wr++;
			if (busy !== 1'b1)
				break;
		end
		if (k == 4000)
		begin
			failures++;
			$display("ERROR %0t: transfer timed out", $time);
			stop_test();
		end
	endtask
	task chk_wr(input logic [15:0] a, input logic [15:0] d, input logic nk);
		check({15'h0000, nack_err}, {15'h0000, nk}, "nack flag");
		check(16'(n_wr), nk ? 16'h0000 : 16'h0001, "words written");
		if (!nk)
		begin
			check(wr_addr, a, "write address");
			check(wr_data, d, "write data");
		end
	endtask
	task chk_rd(input logic [31:0] e, input int n);
		int i;
		check(16'(got.size()), 16'(n), "read byte count");
		for (i = 0; i < n && i < got.size(); i++)
			check({8'h00, got[i]}, {8'h00, e[31 - 8 * i -: 8]}, "read byte");
	endtask
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial
	begin
		failures = 0;
		n_checks = 0;
		reset_n = 1'b0;
		pin_sel = 1'b0;
		ovr_en = 1'b0;
		ovr_addr = 7'h2A;
		req = 1'b0;
		cmd = TW_CMD_WRITE;
		dev = 7'h48;
		reg_a = 16'h0000;
		wdat = 16'h0000;
		nb = 4'h1;
		repeat (12) @(posedge ref_clk);
		#10 reset_n = 1'b1;
		@(posedge ref_clk);
		#10;
		xfer(TW_CMD_WRITE, 7'h48, 16'h0010, 16'hA55A, 4'h1);
		chk_wr(16'h0010, 16'hA55A, 1'b0);
		xfer(TW_CMD_WRITE, 7'h48, 16'h0011, 16'h3CC3, 4'h1);
		chk_wr(16'h0011, 16'h3CC3, 1'b0);
		xfer(TW_CMD_READ, 7'h48, 16'h0010, 16'h0000, 4'h4);
		chk_rd(32'hA55A3CC3, 4);
		xfer(TW_CMD_READ, 7'h48, 16'h0010, 16'h0000, 4'h2);
		chk_rd(32'hA55A0000, 2);
		xfer(TW_CMD_READ_CUR, 7'h48, 16'h0000, 16'h0000, 4'h2);
		chk_rd(32'h3CC30000, 2);
		xfer(TW_CMD_WRITE, 7'h5D, 16'h0020, 16'hBEEF, 4'h1);
		chk_wr(16'h0020, 16'hBEEF, 1'b1);
		pin_sel = 1'b1;
		xfer(TW_CMD_WRITE, 7'h5D, 16'h0020, 16'hBEEF, 4'h1);
		chk_wr(16'h0020, 16'hBEEF, 1'b0);
		xfer(TW_CMD_READ, 7'h5D, 16'h0020, 16'h0000, 4'h2);
		chk_rd(32'hBEEF0000, 2);
		ovr_en = 1'b1;
		xfer(TW_CMD_WRITE, 7'h5D, 16'h0021, 16'h0F0F, 4'h1);
		chk_wr(16'h0021, 16'h0F0F, 1'b1);
		xfer(TW_CMD_WRITE, 7'h2A, 16'h0021, 16'h0F0F, 4'h1);
		chk_wr(16'h0021, 16'h0F0F, 1'b0);
		stop_test();
	end
endmodule

// file: tb/tw_link_asserts.sv
// Checker on the two-wire link signals between the master and slave ends.
// Assumes four ref_clk cycles per bus clock half and that only the master makes start and stop.
`timescale 1ns/100ps
module tw_link_asserts
(
	input	wire logic	ref_clk,	// System clock
	input	wire logic	reset_n,	// Async reset, active low
	input	wire logic	scl_oe,	// Master clock pull-down
	input	wire logic	sda_m_oe,	// Master data pull-down
	input	wire logic	sda_s_oe,	// Slave data pull-down
	input	wire logic	scl,	// Resolved clock level
	input	wire logic	sda	// Resolved data level
);
	logic		scl_q;
	logic		sda_q;
	logic		first;
	logic		next_first;
	logic [3:0]	bitc;
	logic [3:0]	next_bitc;
	logic		start;
	logic		stop;
	logic		rise;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	// Bit count within a frame; the first frame after a start is the address byte
	always_comb
	begin
		start = scl && scl_q && sda_q && !sda;
		stop = scl && scl_q && !sda_q && sda;
		rise = scl && !scl_q;
		next_bitc = bitc;
		next_first = first;
		if (start)
		begin
			next_bitc = 4'h0;
			next_first = 1'b1;
		end
		else if (rise)
		begin
			next_bitc = (bitc == 4'h9) ? 4'h1 : bitc + 4'h1;
			next_first = (bitc == 4'h9) ? 1'b0 : first;
		end
	end
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bitc <= 4'h0;
			first <= 1'b0;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			bitc <= next_bitc;
			first <= next_first;
		end
	end
	property p_addr_quiet;
		first && scl && scl_q && bitc != 4'h9 |-> !sda_s_oe;
	endproperty
	a_addr_quiet: assert property (p_addr_quiet) else $error("slave drove during address byte");
	property p_one_driver;
		scl && scl_q |-> !(sda_s_oe && sda_m_oe);
	endproperty
	a_one_driver: assert property (p_one_driver) else $error("both ends drive data in clock high");
	property p_ack_held;
		rise && bitc == 4'h8 && sda_s_oe |-> sda_s_oe [*4];
	endproperty
	a_ack_held: assert property (p_ack_held) else $error("slave acknowledge not held");
	property p_stop_quiet;
		stop |=> !sda_s_oe [*8];
	endproperty
	a_stop_quiet: assert property (p_stop_quiet) else $error("slave drives after stop");
	property p_scl_low;
		$rose(scl_oe) |-> scl_oe [*4] ##1 !scl_oe;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("clock low half not four cycles");
	property p_scl_high;
		$fell(scl_oe) |-> !scl_oe [*4];
	endproperty
	a_scl_high: assert property (p_scl_high) else $error("clock high half too short");
	property p_slave_change;
		$changed(sda_s_oe) |-> !scl;
	endproperty
	a_slave_change: assert property (p_slave_change) else $error("slave data changed in clock high");
	property p_start_free;
		start |-> !sda_s_oe && $past(sda_m_oe) == 1'b0;
	endproperty
	a_start_free: assert property (p_start_free) else $error("start not made by master");
endmodule

// file: verilog/tw_bus_if.sv
// Two-wire bus between host master and register slave.
// Open-drain: each end drives low via its enable; this interface resolves the wire levels.
`timescale 1ns/100ps
interface tw_bus_if;
	logic	scl_o;	// Master clock output level, tied low
	logic	scl_oe;	// Master clock pull-down enable
	logic	sda_m_oe;	// Master pulls data low
	logic	sda_s_oe;	// Slave pulls data low
	wire	scl = ~scl_oe;	// Resolved clock level
	wire	sda = ~(sda_m_oe | sda_s_oe);	// Resolved data line
	modport master (output scl_o, output scl_oe, output sda_m_oe, input scl, input sda);
	modport slave (output sda_s_oe, input scl, input sda);
endinterface

// file: verilog/tw_consts.svh
// Constants shared by both ends of the two-wire register access link.
// Included by bare name; holds definitions only.
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH
`define TW_ADDR_PIN_LOW   8'h90
`define TW_ADDR_PIN_HIGH  8'hBA
`define TW_BYTE_BITS      4'h8
`define TW_DIR_WRITE      1'b0
`define TW_DIR_READ       1'b1
`define TW_CLK_HALF_NS    400
`define TW_CLK_NS         100
`define TW_HALF_CYC       (`TW_CLK_HALF_NS / `TW_CLK_NS)
`define TW_REG_RESET      16'h0000
`endif

// file: verilog/tw_master.sv
// Host master end: makes the bus clock by dividing ref_clk and runs one transfer per request.
// Assumes the slave acknowledges; a no-acknowledge from the slave aborts with a stop.
`timescale 1ns/100ps
`include "tw_consts.svh"
module tw_master
	import tw_pkg::*;
(
	input	wire logic	ref_clk,	// System clock
	input	wire logic	reset_n,	// Async reset, active low
	tw_bus_if.master	bus,	// Two-wire bus
	input	wire logic	req,	// Start a transfer when idle
	input	wire tw_cmd_e	cmd,	// Write, random read or current read
	input	wire logic [6:0]	dev_addr,	// Slave address
	input	wire logic [15:0]	reg_addr,	// Register address
	input	wire logic [15:0]	wdata,	// Write word
	input	wire logic [3:0]	nbytes,	// Bytes to read
	output	logic	busy,	// Transfer in progress
	output	logic	rvalid,	// One-cycle pulse per byte read
	output	logic [7:0]	rbyte,	// Byte read
	output	logic	nack_err	// Slave did not acknowledge, held until next req
);
	typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} tw_mst_e;

	logic [1:0]	sda_s;
	tw_mst_e	st, next_st;
	logic [3:0]	ph, next_ph;
	logic [3:0]	bitn, next_bitn;
	logic [7:0]	sh, next_sh;
	logic [2:0]	bidx, next_bidx;
	logic [3:0]	left, next_left;
	logic	rdph, next_rdph;
	logic	scl_lo, next_scl_lo, sda_lo, next_sda_lo;
	logic	rv, next_rv, err, next_err;
	tw_cmd_e	c, next_c;
	logic [7:0]	rb, next_rb;
	logic	tick;
	logic [7:0]	nxt;
	logic		scl_drv;
	logic		run, next_run;

	assign tick = ph == 4'(`TW_HALF_CYC - 1);

	// Byte sequence: 0 addr-w (addr-r for current read), 1 reg hi, 2 reg lo, 3 data hi, 4 data lo, 5 addr-r
	// After an acknowledge the byte that follows is loaded, so look one index ahead there
	always_comb
	begin
		unique case ((st == M_ACK) ? bidx + 3'h1 : bidx)
			3'h0: nxt = {dev_addr, (c == TW_CMD_READ_CUR) ? `TW_DIR_READ : `TW_DIR_WRITE};
			3'h1: nxt = reg_addr[15:8];
			3'h2: nxt = reg_addr[7:0];
			3'h3: nxt = wdata[15:8];
			3'h4: nxt = wdata[7:0];
			default: nxt = {dev_addr, `TW_DIR_READ};
		endcase
	end

	always_comb
	begin
		next_st = st;
		next_ph = tick ? 4'h0 : ph + 4'h1;
		next_bitn = bitn;
		next_sh = sh;
		next_bidx = bidx;
		next_left = left;
		next_rdph = rdph;
		next_scl_lo = scl_lo;
		next_sda_lo = sda_lo;
		next_rv = 1'b0;
		next_err = err;
		next_c = c;
		next_rb = rb;
		unique case (st)
			M_IDLE:
			begin
				next_ph = 4'h0;
				if (req)
				begin
					next_c = cmd;
					next_bidx = 3'h0;
					next_left = nbytes;
					next_rdph = 1'b0;
					next_err = 1'b0;
					next_st = M_START;
				end
			end
			M_START:
			begin
				if (tick)
				begin
					if (!scl_lo && !sda_lo)
						next_sda_lo = 1'b1;	// Start or restart
					else if (!scl_lo)
						next_scl_lo = 1'b1;
					else
					begin
						next_sh = nxt;
						next_sda_lo = ~nxt[7];
						next_bitn = 4'h0;
						next_st = M_BIT;
						// First bit set up in the low half; clock rises with it, keeping every low half equal
						next_scl_lo = 1'b0;
					end
				end
			end
			M_BIT:
			begin
				if (tick)
				begin
					next_scl_lo = ~scl_lo;
					if (!scl_lo)
					begin
						next_sh = {sh[6:0], sda_s[1]};
						next_bitn = bitn + 4'h1;
					end
					else if (bitn == `TW_BYTE_BITS)
					begin
						// Receiver acknowledges low; master acks all but the last
						next_sda_lo = rdph && left > 4'h1;
						next_st = M_ACK;
					end
					else
						next_sda_lo = rdph ? 1'b0 : ~sh[7];
				end
			end
			M_ACK:
			begin
				if (tick)
				begin
					next_scl_lo = ~scl_lo;
					if (!scl_lo && rdph)
					begin
						next_rb = sh;
						next_rv = 1'b1;
						next_left = left - 4'h1;
					end
					else if (!scl_lo && sda_s[1])
						next_err = 1'b1;
					else if (scl_lo)
					begin
						next_bitn = 4'h0;
						if (err || (rdph && left == 4'h0))
						begin
							next_sda_lo = 1'b1;	// No-acknowledge sent; now stop
							next_st = M_STOP;
						end
						else if (rdph)
						begin
							next_sda_lo = 1'b0;
							next_st = M_BIT;
						end
						else if ((bidx == 3'h2 && c == TW_CMD_READ) || bidx == 3'h0 && c == TW_CMD_READ_CUR)
						begin
							next_bidx = 3'h5;
							next_sda_lo = 1'b0;
							next_rdph = c == TW_CMD_READ_CUR;
							next_st = (c == TW_CMD_READ_CUR) ? M_BIT : M_START;
						end
						else if (bidx == 3'h5)
						begin
							next_rdph = 1'b1;
							next_sda_lo = 1'b0;
							next_st = M_BIT;
						end
						else if (bidx == 3'h4)
						begin
							next_sda_lo = 1'b1;
							next_st = M_STOP;
						end
						else
						begin
							next_bidx = bidx + 3'h1;
							next_sh = nxt;
							next_st = M_BIT;
							next_sda_lo = 1'b0;
						end
					end
				end
			end
			M_STOP:
			begin
				if (tick)
				begin
					if (scl_lo)
						next_scl_lo = 1'b0;
					else
					begin
						next_sda_lo = 1'b0;
						next_st = M_IDLE;
					end
				end
			end
			default:
			begin
				next_st = M_IDLE;
			end
		endcase
		// Data loaded while clock low for the next bit
		if (st == M_BIT && tick && scl_lo && bitn == 4'h0 && !rdph)
			next_sda_lo = ~sh[7];
		if (st == M_BIT && tick && scl_lo && bitn != 4'h0 && bitn != `TW_BYTE_BITS && !rdph)
			next_sda_lo = ~sh[7];
		if (st == M_ACK && tick && scl_lo && next_st == M_BIT && !next_rdph)
			next_sda_lo = ~next_sh[7];
		if (st == M_ACK && tick && scl_lo && next_st == M_BIT && bidx == 3'h0 && c == TW_CMD_READ_CUR)
			next_sda_lo = 1'b0;
		next_run = next_st != M_IDLE;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sda_s <= 2'h3;
			st <= M_IDLE;
			ph <= 4'h0;
			bitn <= 4'h0;
			sh <= 8'h00;
			bidx <= 3'h0;
			left <= 4'h0;
			rdph <= 1'b0;
			scl_lo <= 1'b0;
			sda_lo <= 1'b0;
			rv <= 1'b0;
			err <= 1'b0;
			c <= TW_CMD_WRITE;
			rb <= 8'h00;
			scl_drv <= 1'b0;
			run <= 1'b0;
		end
		else
		begin
			sda_s <= {sda_s[0], bus.sda};
			st <= next_st;
			ph <= next_ph;
			bitn <= next_bitn;
			sh <= next_sh;
			bidx <= next_bidx;
			left <= next_left;
			rdph <= next_rdph;
			scl_lo <= next_scl_lo;
			sda_lo <= next_sda_lo;
			rv <= next_rv;
			err <= next_err;
			c <= next_c;
			rb <= next_rb;
			scl_drv <= scl_lo;
			run <= next_run;
		end
	end

	assign bus.scl_o = 1'b0;
	// Clock lags data by one cycle so data never moves on a clock edge
	assign bus.scl_oe = scl_drv;
	assign bus.sda_m_oe = sda_lo;
	assign busy = run;
	assign rvalid = rv;
	assign rbyte = rb;
	assign nack_err = err;
endmodule

// file: verilog/tw_pkg.sv
// Types shared by both ends of the two-wire register access link.
package tw_pkg;
	typedef enum logic [1:0] {TW_CMD_WRITE, TW_CMD_READ, TW_CMD_READ_CUR} tw_cmd_e;
	typedef logic [15:0] tw_word_t;
endpackage

// file: verilog/tw_slave.sv
// Notes on behaviour
// - Address byte follows start; bit0 is direction
// - Acknowledge only matching seven-bit slave address
// - Write: two register address bytes, each acknowledged
// - Two data bytes follow, each acknowledged
// - Master ends writes with restart or stop
// - Random read: address write, restart, read
// - Master no-acknowledge stops slave read data
// - Single read returns sixteen-bit register as two bytes
// - Read without address uses last held address
// - Keep supplying bytes while master acknowledges
// - Address and data sent high byte first
// - Sequential writes continue until stop
// - Address 0x90 pin low, 0xBA high, overridable
// - Bytes are eight bits, MSB first
// - Transmitter releases data; receiver acknowledges low
// Register slave end: samples the bus on ref_clk through two flops and finds edges.
// Assumes the bus is slow against ref_clk (at least four ref_clk cycles per clock half).
`timescale 1ns/100ps
`include "tw_consts.svh"
module tw_slave
	import tw_pkg::*;
#(
	parameter int REG_COUNT = 256	// Registers held; word index is address modulo this
)
(
	input	wire logic	ref_clk,	// System clock
	input	wire logic	reset_n,	// Async reset, active low
	tw_bus_if.slave	bus,	// Two-wire bus
	input	wire logic	slave_address_select_pin,	// Address select strap
	input	wire logic	addr_override_en,	// Use override address
	input	wire logic [6:0]	addr_override,	// Override seven-bit address
	output	logic	wr_strobe,	// One-cycle pulse per word written
	output	logic [15:0]	wr_addr,	// Address of written word
	output	logic [15:0]	wr_data	// Data of written word
);
	localparam int IW = $clog2(REG_COUNT);
	initial
	begin
		if (REG_COUNT < 2 || (REG_COUNT & (REG_COUNT - 1)) != 0)
			$error("REG_COUNT must be a power of two");
	end

	typedef enum logic [2:0] {S_IDLE, S_RECV, S_RACK, S_SEND, S_SACK, S_SKIP} tw_sst_e;

	tw_word_t	regs [REG_COUNT];
	logic [1:0]	scl_s, sda_s;
	logic [1:0]	pin_s;
	logic	scl_d, sda_d;
	tw_sst_e	st, next_st;
	logic [3:0]	bitn, next_bitn;
	logic [7:0]	sh, next_sh;
	logic [2:0]	idx, next_idx;
	logic	rd, next_rd;
	tw_word_t	ptr, next_ptr;
	logic [7:0]	hi, next_hi;
	logic	oe, next_oe;
	logic	odd, next_odd;
	logic	wst, next_wst;
	tw_word_t	wa, next_wa, wd, next_wd;
	logic [6:0]	my_addr;
	logic	scl_rise, scl_fall, start_c, stop_c;
	logic [7:0]	rbyte;

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			pin_s <= 2'h0;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_s <= {scl_s[0], bus.scl};
			sda_s <= {sda_s[0], bus.sda};
			pin_s <= {pin_s[0], slave_address_select_pin};
			scl_d <= scl_s[1];
			sda_d <= sda_s[1];
		end
	end

	assign scl_rise = scl_s[1] & ~scl_d;
	assign scl_fall = ~scl_s[1] & scl_d;
	assign start_c = scl_s[1] & scl_d & sda_d & ~sda_s[1];
	assign stop_c = scl_s[1] & scl_d & ~sda_d & sda_s[1];
	// Override input replaces the strap address when enabled
	assign my_addr = addr_override_en ? addr_override
		: (pin_s[1] ? 7'(`TW_ADDR_PIN_HIGH >> 1) : 7'(`TW_ADDR_PIN_LOW >> 1));
	// High byte first from the current word
	assign rbyte = odd ? regs[ptr[IW-1:0]][7:0] : regs[ptr[IW-1:0]][15:8];

	always_comb
	begin
		next_st = st;
		next_bitn = bitn;
		next_sh = sh;
		next_idx = idx;
		next_rd = rd;
		next_ptr = ptr;
		next_hi = hi;
		next_oe = oe;
		next_odd = odd;
		next_wst = 1'b0;
		next_wa = wa;
		next_wd = wd;
		if (stop_c)
		begin
			// Transfer ends on stop; restart handled below
			next_st = S_IDLE;
			next_oe = 1'b0;
		end
		else if (start_c)
		begin
			next_st = S_RECV;
			next_bitn = 4'h0;
			next_idx = 3'h0;
			next_oe = 1'b0;
		end
		else
		begin
			unique case (st)
				S_IDLE, S_SKIP:
				begin
					next_oe = 1'b0;
				end
				S_RECV:
				begin
					if (scl_rise)
					begin
						next_sh = {sh[6:0], sda_s[1]};
						next_bitn = bitn + 4'h1;
					end
					if (scl_fall && bitn == `TW_BYTE_BITS)
					begin
						next_bitn = 4'h0;
						next_st = S_RACK;
						next_oe = 1'b1;
						if (idx == 3'h0)
						begin
							// Address byte: direction in bit0
							if (sh[7:1] != my_addr)
							begin
								next_st = S_SKIP;
								next_oe = 1'b0;
							end
							next_rd = sh[0] == `TW_DIR_READ;
							next_odd = 1'b0;
						end
						else if (idx == 3'h1)
						begin
							next_hi = sh;
						end
						else if (idx == 3'h2)
						begin
							next_ptr = {hi, sh};
							next_odd = 1'b0;
						end
						else if (!odd)
						begin
							next_hi = sh;
							next_odd = 1'b1;
						end
						else
						begin
							next_wst = 1'b1;
							next_wa = ptr;
							next_wd = {hi, sh};
							next_ptr = ptr + 16'h1;
							next_odd = 1'b0;
						end
						if (idx != 3'h3)
							next_idx = idx + 3'h1;
					end
				end
				S_RACK:
				begin
					if (scl_fall)
					begin
						if (rd)
						begin
							next_st = S_SEND;
							next_sh = rbyte;
							next_oe = ~rbyte[7];
							next_bitn = 4'h1;
						end
						else
						begin
							next_st = S_RECV;
							next_oe = 1'b0;
						end
					end
				end
				S_SEND:
				begin
					if (scl_fall)
					begin
						if (bitn == `TW_BYTE_BITS)
						begin
							next_st = S_SACK;
							next_oe = 1'b0;
						end
						else
						begin
							next_oe = ~sh[7 - bitn[2:0]];
							next_bitn = bitn + 4'h1;
						end
					end
				end
				S_SACK:
				begin
					if (scl_rise)
					begin
						if (odd)
							next_ptr = ptr + 16'h1;
						next_odd = ~odd;
						// No-acknowledge ends read data acknowledge continues
						next_st = sda_s[1] ? S_SKIP : S_RACK;
					end
				end
				default:
				begin
					next_st = S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st <= S_IDLE;
			bitn <= 4'h0;
			sh <= 8'h00;
			idx <= 3'h0;
			rd <= 1'b0;
			ptr <= `TW_REG_RESET;
			hi <= 8'h00;
			oe <= 1'b0;
			odd <= 1'b0;
			wst <= 1'b0;
			wa <= 16'h0000;
			wd <= 16'h0000;
		end
		else
		begin
			st <= next_st;
			bitn <= next_bitn;
			sh <= next_sh;
			idx <= next_idx;
			rd <= next_rd;
			ptr <= next_ptr;
			hi <= next_hi;
			oe <= next_oe;
			odd <= next_odd;
			wst <= next_wst;
			wa <= next_wa;
			wd <= next_wd;
		end
	end

	// Register store has no reset, as a RAM would not
	always_ff @(posedge ref_clk)
	begin
		if (wst)
			regs[wa[IW-1:0]] <= wd;
	end

	assign bus.sda_s_oe = oe;
	assign wr_strobe = wst;
	assign wr_addr = wa;
	assign wr_data = wd;
endmodule
